// [rtl/pm_mode_ctrl.sv]
// Mode state machine, fan cleaning timer, result layout and health word.
// Assumes commands arrive decoded on the system clock; sensor flags come from pins.
`timescale 1ns/100ps
module pm_mode_ctrl #(
	parameter int TICK_CYCLES = pm_mode_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Host command port
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [31:0] cmd_param_in,
	output logic rsp_valid_out,
	output logic [7:0] rsp_state_out,
	output logic serial_en_out,
	// Result read port
	input wire logic rd_en_in,
	input wire logic [5:0] rd_addr_in,
	output logic [7:0] rd_data_out,
	output logic results_new_out,
	// Raw results, word 0 in the top bits
	input wire logic [319:0] meas_float_in,
	input wire logic [159:0] meas_uint_in,
	// Sensor pins
	input wire logic fan_speed_ok_in,
	input wire logic fan_zero_in,
	input wire logic laser_ok_in,
	// Non-volatile interval store
	input wire logic nvm_load_in,
	input wire logic [31:0] nvm_data_in,
	output logic nvm_wr_out,
	output logic [31:0] nvm_data_out,
	// Actuators and status
	output logic fan_on_out,
	output logic fan_max_out,
	output logic laser_on_out,
	output logic [2:0] mode_out,
	output logic [31:0] health_out
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	pm_mode_pkg::mode_type mode_reg;
	logic [TW-1:0] tick_cnt_reg;
	logic tick_reg;
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic fmt_float_reg;
	logic clean_active_reg;
	logic [3:0] clean_cnt_reg;
	logic [31:0] interval_reg;
	logic [31:0] elapsed_reg;
	logic [1:0] start_cnt_reg;
	logic speed_miss_reg;
	logic laser_miss_reg;
	logic zero_miss_reg;
	logic speed_warn_reg;
	logic laser_err_reg;
	logic fan_err_reg;
	logic [319:0] snap_float_reg;
	logic [159:0] snap_uint_reg;

	logic cmd_take;
	logic start_ok;
	logic stop_ok;
	logic sleep_ok;
	logic wake_ok;
	logic clean_ok;
	logic intv_wr;
	logic reset_cmd;
	logic [6:0] err_code;
	logic measuring;
	logic auto_due;
	logic clean_start;
	logic speed_check;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {fan_speed_ok_in, fan_zero_in, laser_ok_in};
			sync2_reg <= sync1_reg;
		end
	end

	// ==========================================================
	// Command decode
	assign measuring = (mode_reg == pm_mode_pkg::MODE_MEAS);
	assign cmd_take = cmd_valid_in && (mode_reg != pm_mode_pkg::MODE_SLEEP || cmd_code_in == pm_mode_pkg::CMD_WAKE);

	always_comb begin
		start_ok = 1'b0;
		stop_ok = 1'b0;
		sleep_ok = 1'b0;
		wake_ok = 1'b0;
		clean_ok = 1'b0;
		intv_wr = 1'b0;
		reset_cmd = 1'b0;
		err_code = pm_mode_pkg::ERR_NONE;
		if (cmd_take) begin
			unique case (cmd_code_in)
				pm_mode_pkg::CMD_START: begin
					if (mode_reg != pm_mode_pkg::MODE_IDLE) begin
						err_code = pm_mode_pkg::ERR_STATE;
					end else if (cmd_param_in[7:0] != pm_mode_pkg::FMT_FLOAT &&
						cmd_param_in[7:0] != pm_mode_pkg::FMT_UINT16) begin
						err_code = pm_mode_pkg::ERR_PARAM;
					end else begin
						start_ok = 1'b1;
					end
				end
				pm_mode_pkg::CMD_STOP: begin
					if (!measuring) begin
						err_code = pm_mode_pkg::ERR_STATE;
					end else begin
						stop_ok = 1'b1;
					end
				end
				pm_mode_pkg::CMD_SLEEP: begin
					if (mode_reg != pm_mode_pkg::MODE_IDLE) begin
						err_code = pm_mode_pkg::ERR_STATE;
					end else begin
						sleep_ok = 1'b1;
					end
				end
				pm_mode_pkg::CMD_WAKE: begin
					wake_ok = (mode_reg == pm_mode_pkg::MODE_SLEEP);
				end
				pm_mode_pkg::CMD_CLEAN: begin
					if (!measuring) begin
						err_code = pm_mode_pkg::ERR_STATE;
					end else begin
						clean_ok = 1'b1;
					end
				end
				pm_mode_pkg::CMD_INTERVAL: begin
					intv_wr = 1'b1;
				end
				pm_mode_pkg::CMD_RESET: begin
					reset_cmd = 1'b1;
				end
				default: begin
					err_code = pm_mode_pkg::ERR_UNKNOWN;
				end
			endcase
		end
	end

	// ==========================================================
	// Mode state machine
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			mode_reg <= pm_mode_pkg::MODE_IDLE;
		end else if (reset_cmd || stop_ok || wake_ok) begin
			mode_reg <= pm_mode_pkg::MODE_IDLE;
		end else if (start_ok) begin
			mode_reg <= pm_mode_pkg::MODE_MEAS;
		end else if (sleep_ok) begin
			mode_reg <= pm_mode_pkg::MODE_SLEEP;
		end
	end

	// Output format
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			fmt_float_reg <= 1'b1;
		end else if (start_ok) begin
			fmt_float_reg <= (cmd_param_in[7:0] == pm_mode_pkg::FMT_FLOAT);
		end
	end

	// Response
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_state_out <= 8'h00;
		end else begin
			rsp_valid_out <= cmd_take;
			if (cmd_take) begin
				rsp_state_out <= {laser_err_reg | fan_err_reg, err_code};
			end
		end
	end

	// ==========================================================
	// One second tick, phased to measurement start
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || start_ok || !measuring) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == TICK_LAST) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + TW'(1);
			tick_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Cleaning interval store
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			interval_reg <= pm_mode_pkg::INTERVAL_DEFAULT_S;
			nvm_wr_out <= 1'b0;
			nvm_data_out <= 32'h0000_0000;
		end else begin
			nvm_wr_out <= intv_wr;
			if (intv_wr) begin
				interval_reg <= cmd_param_in;
				nvm_data_out <= cmd_param_in;
			end else if (nvm_load_in) begin
				interval_reg <= nvm_data_in;
			end
		end
	end

	// Elapsed time and cleaning cycle
	assign auto_due = tick_reg && measuring && !clean_active_reg && interval_reg != 32'h0000_0000 &&
		(elapsed_reg + 32'h0000_0001) >= interval_reg;
	assign clean_start = auto_due || clean_ok;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || clean_start) begin
			elapsed_reg <= 32'h0000_0000;
		end else if (tick_reg && measuring && !clean_active_reg) begin
			elapsed_reg <= elapsed_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !measuring || stop_ok || reset_cmd) begin
			clean_active_reg <= 1'b0;
			clean_cnt_reg <= 4'h0;
		end else if (clean_start) begin
			clean_active_reg <= 1'b1;
			clean_cnt_reg <= 4'h0;
		end else if (clean_active_reg && tick_reg) begin
			if (clean_cnt_reg == pm_mode_pkg::CLEAN_S - 4'h1) begin
				clean_active_reg <= 1'b0;
			end
			clean_cnt_reg <= clean_cnt_reg + 4'h1;
		end
	end

	// ==========================================================
	// Result snapshot, frozen during cleaning
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			snap_float_reg <= '0;
			snap_uint_reg <= '0;
			results_new_out <= 1'b0;
		end else begin
			results_new_out <= tick_reg && measuring && !clean_active_reg;
			if (tick_reg && measuring && !clean_active_reg) begin
				snap_float_reg <= meas_float_in;
				snap_uint_reg <= meas_uint_in;
			end
		end
	end

	// Big-endian byte read in the chosen format
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			if (fmt_float_reg && rd_addr_in < pm_mode_pkg::FLOAT_BYTES) begin
				rd_data_out <= snap_float_reg[319 - 8 * int'(rd_addr_in) -: 8];
			end else if (!fmt_float_reg && rd_addr_in < pm_mode_pkg::UINT_BYTES) begin
				rd_data_out <= snap_uint_reg[159 - 8 * int'(rd_addr_in) -: 8];
			end else begin
				rd_data_out <= 8'h00;
			end
		end
	end

	// ==========================================================
	// Health checks
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || start_ok) begin
			start_cnt_reg <= 2'h0;
		end else if (tick_reg && start_cnt_reg != pm_mode_pkg::STARTUP_S) begin
			start_cnt_reg <= start_cnt_reg + 2'h1;
		end
	end

	assign speed_check = tick_reg && measuring && start_cnt_reg == pm_mode_pkg::STARTUP_S && !clean_active_reg;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !measuring) begin
			speed_miss_reg <= 1'b0;
			speed_warn_reg <= rst_in ? 1'b0 : speed_warn_reg;
		end else if (speed_check) begin
			speed_miss_reg <= !sync2_reg[2];
			if (sync2_reg[2]) begin
				speed_warn_reg <= 1'b0;
			end else if (speed_miss_reg) begin
				speed_warn_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !measuring) begin
			laser_miss_reg <= 1'b0;
			laser_err_reg <= rst_in ? 1'b0 : laser_err_reg;
		end else if (tick_reg) begin
			laser_miss_reg <= !sync2_reg[0];
			if (sync2_reg[0]) begin
				laser_err_reg <= 1'b0;
			end else if (laser_miss_reg) begin
				laser_err_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			zero_miss_reg <= 1'b0;
			fan_err_reg <= 1'b0;
		end else if (!measuring) begin
			zero_miss_reg <= 1'b0;
		end else if (tick_reg) begin
			zero_miss_reg <= sync2_reg[1];
			if (sync2_reg[1] && zero_miss_reg) begin
				fan_err_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			fan_on_out <= 1'b0;
			laser_on_out <= 1'b0;
			fan_max_out <= 1'b0;
			serial_en_out <= 1'b1;
			mode_out <= pm_mode_pkg::MODE_IDLE;
			health_out <= 32'h0000_0000;
		end else begin
			fan_on_out <= measuring;
			laser_on_out <= measuring;
			fan_max_out <= clean_active_reg;
			serial_en_out <= (mode_reg != pm_mode_pkg::MODE_SLEEP);
			mode_out <= mode_reg;
			health_out <= 32'h0000_0000;
			health_out[pm_mode_pkg::HEALTH_SPEED_BIT] <= speed_warn_reg;
			health_out[pm_mode_pkg::HEALTH_LASER_BIT] <= laser_err_reg;
			health_out[pm_mode_pkg::HEALTH_FAN_BIT] <= fan_err_reg;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	chk_reset_idle: assert property ($past(rst_in) |-> mode_reg == pm_mode_pkg::MODE_IDLE)
		else $error("mode not idle after reset");
	chk_idle_outputs: assert property (mode_reg != pm_mode_pkg::MODE_MEAS |=> !fan_on_out && !laser_on_out)
		else $error("fan or laser on outside measurement");
	chk_meas_entry: assert property (mode_reg != pm_mode_pkg::MODE_MEAS ##1 mode_reg == pm_mode_pkg::MODE_MEAS
		|-> $past(mode_reg) == pm_mode_pkg::MODE_IDLE)
		else $error("measurement entered from non-idle");
	chk_sleep_entry: assert property ($rose(mode_reg == pm_mode_pkg::MODE_SLEEP)
		|-> $past(mode_reg) == pm_mode_pkg::MODE_IDLE)
		else $error("sleep entered from non-idle");
	chk_sleep_silent: assert property (mode_reg == pm_mode_pkg::MODE_SLEEP && cmd_valid_in &&
		cmd_code_in != pm_mode_pkg::CMD_WAKE |=> !rsp_valid_out)
		else $error("response given while asleep");
	chk_state_error: assert property (cmd_valid_in && cmd_code_in == pm_mode_pkg::CMD_SLEEP &&
		mode_reg == pm_mode_pkg::MODE_MEAS |=> rsp_valid_out && rsp_state_out[6:0] == 7'h43)
		else $error("illegal transition not refused");
	chk_clean_freeze: assert property (clean_active_reg |=> $stable(snap_float_reg) && !results_new_out)
		else $error("results changed during cleaning");
	chk_manual_clean: assert property (cmd_valid_in && cmd_code_in == pm_mode_pkg::CMD_CLEAN && measuring
		|=> ##1 fan_max_out)
		else $error("manual cleaning did not start");
	chk_fan_sticky: assert property (fan_err_reg |=> fan_err_reg)
		else $error("fan stall error cleared");
	chk_status_flag: assert property (rsp_valid_out |-> rsp_state_out[7] == $past(laser_err_reg | fan_err_reg))
		else $error("status byte error flag wrong");
	chk_laser_set: assert property (tick_reg && measuring && !sync2_reg[0] && laser_miss_reg |=> laser_err_reg)
		else $error("laser error not set");
	chk_speed_skip: assert property (clean_active_reg && tick_reg |=> $stable(speed_warn_reg))
		else $error("speed checked during cleaning");

	cov_meas_start: cover property (start_ok ##1 measuring);
	cov_sleep_wake: cover property (sleep_ok ##[1:20] wake_ok);
	cov_clean_done: cover property ($fell(clean_active_reg) && measuring);
	cov_fan_stall: cover property ($rose(fan_err_reg));
endmodule

// [rtl/pm_mode_pkg.sv]
// Constants, codes and types for the particulate sensor mode and health controller.
// Assumes one 20 MHz system clock and a host command front end on the same clock.
// Operation
// - After power-on or any reset the controller is in Idle mode.
// - Idle keeps fan and laser off and takes every command.
// - Measurement mode is entered only from Idle.
// - In Measurement a fresh result set is published every second.
// - Sleep mode is entered only from Idle.
// - Sleep disables the host interface; host must wake the device first.
// - In Measurement an elapsed interval starts ten seconds of full-speed fan cleaning.
// - Published results stay frozen while a cleaning cycle runs.
// - Cleaning interval defaults to 604800 seconds, within three percent.
// - Interval zero disables automatic cleaning; other values set the period.
// - A written interval is pushed to non-volatile memory.
// - Power loss restarts the elapsed cleaning time from zero.
// - The manual cleaning command starts a cleaning cycle at once.
// - Start command picks the output format; later reads use that format.
// - Float format gives ten big-endian words: four mass, five number, size.
// - Integer format gives ten big-endian 16-bit values, size in nanometres.
// - A 32-bit health word is kept; reserved bits are to be ignored.
// - No fan speed check in first three seconds or during cleaning.
// - Otherwise speed checked each second; two misses set bit 21.
// - Speed warning clears itself once the fan reaches target speed.
// - Laser current checked each second; two misses set bit 5.
// - Laser error clears itself when current is back within limits.
// - Fan checked each second; zero speed twice sets bit 4.
// - Fan stall error stays set and is never cleared automatically.
// - Every response status byte has bit 7 set when any error flag is set.
// - Format code 0x03 selects floats, 0x05 selects 16-bit integers.
// - A transition not allowed from the current mode is refused with 0x43; a wake command outside Sleep gets code 0x00 instead.
package pm_mode_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int SECOND_S = 1;
	localparam int TICK_CYCLES = SECOND_S * CLK_HZ;
	localparam logic [3:0] CLEAN_S = 4'hA;
	localparam logic [1:0] STARTUP_S = 2'h3;
	localparam logic [31:0] INTERVAL_DEFAULT_S = 32'h0009_3A80;
	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_START = 8'h00;
	localparam logic [7:0] CMD_STOP = 8'h01;
	localparam logic [7:0] CMD_SLEEP = 8'h10;
	localparam logic [7:0] CMD_WAKE = 8'h11;
	localparam logic [7:0] CMD_CLEAN = 8'h56;
	localparam logic [7:0] CMD_INTERVAL = 8'h80;
	localparam logic [7:0] CMD_RESET = 8'hD3;
	localparam logic [7:0] FMT_FLOAT = 8'h03;
	localparam logic [7:0] FMT_UINT16 = 8'h05;
	// ==========================================================
	// Execution error codes and status byte
	localparam logic [6:0] ERR_NONE = 7'h00;
	localparam logic [6:0] ERR_UNKNOWN = 7'h02;
	localparam logic [6:0] ERR_PARAM = 7'h04;
	localparam logic [6:0] ERR_STATE = 7'h43;
	localparam int STATUS_ERR_BIT = 7;
	// ==========================================================
	// Health word bits and result layout
	localparam int HEALTH_SPEED_BIT = 21;
	localparam int HEALTH_LASER_BIT = 5;
	localparam int HEALTH_FAN_BIT = 4;
	localparam logic [5:0] FLOAT_BYTES = 6'h28;
	localparam logic [5:0] UINT_BYTES = 6'h14;
	// ==========================================================
	// Modes
	typedef enum logic [2:0] {
		MODE_IDLE = 3'b001,
		MODE_MEAS = 3'b010,
		MODE_SLEEP = 3'b100
	} mode_type;
endpackage

// [dv/pm_host_model.sv]
// Host model: issues decoded commands and reads result bytes.
// Assumes each call starts just after a rising edge of the system clock.
`timescale 1ns/100ps
module pm_host_model (
	// Clock
	input wire logic clk_sys_in,
	// Command side
	output logic cmd_valid_out,
	output logic [7:0] cmd_code_out,
	output logic [31:0] cmd_param_out,
	input wire logic rsp_valid_in,
	input wire logic [7:0] rsp_state_in,
	// Read side
	output logic rd_en_out,
	output logic [5:0] rd_addr_out,
	input wire logic [7:0] rd_data_in
);
	// ==========================================================
	// Idle levels
	initial begin
		cmd_valid_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_param_out = 32'h0000_0000;
		rd_en_out = 1'b0;
		rd_addr_out = 6'h00;
	end
	// ==========================================================
	// Command, then one idle cycle; released lines flip
	task automatic send(input logic [7:0] code, input logic [31:0] param, output logic got,
		output logic [7:0] st);
		cmd_valid_out = 1'b1;
		cmd_code_out = code;
		cmd_param_out = param;
		@(posedge clk_sys_in);
		#1;
		got = rsp_valid_in;
		st = rsp_state_in;
		cmd_valid_out = 1'b0;
		cmd_code_out = ~code;
		cmd_param_out = ~param;
		@(posedge clk_sys_in);
		#1;
	endtask
	// ==========================================================
	// Single byte read, then one idle cycle
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		rd_en_out = 1'b1;
		rd_addr_out = a;
		@(posedge clk_sys_in);
		#1;
		d = rd_data_in;
		rd_en_out = 1'b0;
		rd_addr_out = ~a;
		@(posedge clk_sys_in);
		#1;
	endtask
endmodule

// [dv/test_pm_mode_ctrl.sv]
// Self-checking bench for the mode and health controller.
// Assumes the host model drives commands; sensor pins and results come from here.
`timescale 1ns/100ps
module test_pm_mode_ctrl;
	localparam int T = 8;
	logic clk_sys_in;
	logic rst_in;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic [31:0] cmd_param;
	logic rsp_valid;
	logic [7:0] rsp_state;
	logic serial_en;
	logic rd_en;
	logic [5:0] rd_addr;
	logic [7:0] rd_data;
	logic results_new;
	logic [319:0] meas_float;
	logic [159:0] meas_uint;
	logic fan_speed_ok;
	logic fan_zero;
	logic laser_ok;
	logic nvm_load;
	logic [31:0] nvm_data;
	logic nvm_wr;
	logic [31:0] nvm_q;
	logic fan_on;
	logic fan_max;
	logic laser_on;
	logic [2:0] mode;
	logic [31:0] health;
	int bad_count;
	int tests_run;
	int wr_count;
	logic got;
	logic [7:0] st;
	logic [7:0] d;
	logic [7:0] old_b;
	// ==========================================================
	// Instances
	pm_mode_ctrl #(.TICK_CYCLES(T)) i_pm_mode_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_param_in(cmd_param), .rsp_valid_out(rsp_valid),
		.rsp_state_out(rsp_state), .serial_en_out(serial_en), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
		.rd_data_out(rd_data), .results_new_out(results_new), .meas_float_in(meas_float),
		.meas_uint_in(meas_uint), .fan_speed_ok_in(fan_speed_ok), .fan_zero_in(fan_zero),
		.laser_ok_in(laser_ok), .nvm_load_in(nvm_load), .nvm_data_in(nvm_data), .nvm_wr_out(nvm_wr),
		.nvm_data_out(nvm_q), .fan_on_out(fan_on), .fan_max_out(fan_max), .laser_on_out(laser_on),
		.mode_out(mode), .health_out(health));
	pm_host_model i_pm_host_model (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid),
		.cmd_code_out(cmd_code), .cmd_param_out(cmd_param), .rsp_valid_in(rsp_valid),
		.rsp_state_in(rsp_state), .rd_en_out(rd_en), .rd_addr_out(rd_addr), .rd_data_in(rd_data));
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	// Counts store write strobes
	always @(posedge clk_sys_in) begin
		if (nvm_wr === 1'b1) begin
			wr_count++;
		end
	end
	// ==========================================================
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic stop_test();
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic sig(input int sel);
		case (sel)
			0: return results_new;
			1: return fan_max;
			2: return health[21];
			3: return health[5];
			default: return health[4];
		endcase
	endfunction
	task automatic wait_sig(input int sel, input logic v, input int lim);
		for (int i = 0; i < lim && sig(sel) !== v; i++) step(1);
		chk(sig(sel), v);
		if (sig(sel) !== v) stop_test();
	endtask
	task automatic do_reset();
		rst_in = 1'b1;
		step(3);
		rst_in = 1'b0;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [31:0] p, input logic [8:0] e);
		i_pm_host_model.send(c, p, got, st);
		step(1);
		chk({got, st}, e);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		i_pm_host_model.rd(a, d);
		chk(d, e);
	endtask
	task automatic load_nvm(input logic [31:0] v);
		nvm_data = v;
		nvm_load = 1'b1;
		step(1);
		nvm_load = 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_modes();
		do_reset();
		chk({mode, serial_en, fan_on, laser_on, fan_max}, {3'b001, 4'b1000});
		cmd(8'h7F, 32'h0, 9'h102);
		cmd(pm_mode_pkg::CMD_STOP, 32'h0, 9'h143);
		cmd(pm_mode_pkg::CMD_CLEAN, 32'h0, 9'h143);
		cmd(pm_mode_pkg::CMD_START, 32'h7, 9'h104);
		cmd(pm_mode_pkg::CMD_SLEEP, 32'h0, 9'h100);
		chk({mode, serial_en}, {3'b100, 1'b0});
		i_pm_host_model.send(pm_mode_pkg::CMD_START, 32'h3, got, st);
		chk(got, 1'b0);
		cmd(pm_mode_pkg::CMD_WAKE, 32'h0, 9'h100);
		chk({mode, serial_en}, {3'b001, 1'b1});
		cmd(pm_mode_pkg::CMD_START, 32'h5, 9'h100);
		chk({mode, fan_on, laser_on}, {3'b010, 2'b11});
		cmd(pm_mode_pkg::CMD_START, 32'h3, 9'h143);
		cmd(pm_mode_pkg::CMD_SLEEP, 32'h0, 9'h143);
		cmd(pm_mode_pkg::CMD_STOP, 32'h0, 9'h100);
		chk({mode, fan_on, laser_on}, {3'b001, 2'b00});
		cmd(pm_mode_pkg::CMD_START, 32'h3, 9'h100);
		cmd(pm_mode_pkg::CMD_RESET, 32'h0, 9'h100);
		chk(mode, 3'b001);
	endtask
	task automatic t_results();
		cmd(pm_mode_pkg::CMD_START, 32'h3, 9'h100);
		wait_sig(0, 1'b1, 2 * T);
		step(T);
		chk(results_new, 1'b1);
		for (int a = 0; a < 40; a += 13) begin
			rd_chk(6'(a), meas_float[319 - 8 * a -: 8]);
		end
		rd_chk(6'h28, 8'h00);
		cmd(pm_mode_pkg::CMD_STOP, 32'h0, 9'h100);
		cmd(pm_mode_pkg::CMD_START, 32'h5, 9'h100);
		wait_sig(0, 1'b1, 2 * T);
		for (int a = 1; a < 20; a += 6) begin
			rd_chk(6'(a), meas_uint[159 - 8 * a -: 8]);
		end
		rd_chk(6'h14, 8'h00);
	endtask
	task automatic t_clean();
		int n;
		cmd(pm_mode_pkg::CMD_CLEAN, 32'h0, 9'h100);
		chk(fan_max, 1'b1);
		fan_speed_ok = 1'b0;
		old_b = meas_uint[159:152];
		meas_uint = ~meas_uint;
		n = 0;
		while (fan_max === 1'b1 && n < 11 * T) begin
			if (n == T) begin
				rd_chk(6'h00, old_b);
				n += 2;
			end else begin
				step(1);
				n++;
			end
			if (results_new !== 1'b0) chk(results_new, 1'b0);
		end
		chk(n > 9 * T - 4 && n <= 10 * T, 1'b1);
		chk(health[21], 1'b0);
		fan_speed_ok = 1'b1;
		wait_sig(0, 1'b1, 2 * T);
		rd_chk(6'h00, meas_uint[159:152]);
	endtask
	task automatic t_auto();
		do_reset();
		load_nvm(32'h3);
		cmd(pm_mode_pkg::CMD_START, 32'h3, 9'h100);
		step(2 * T);
		do_reset();
		load_nvm(32'h3);
		cmd(pm_mode_pkg::CMD_START, 32'h3, 9'h100);
		for (int i = 0; i < 2 * T; i++) begin
			step(1);
			if (fan_max !== 1'b0) chk(fan_max, 1'b0);
		end
		wait_sig(1, 1'b1, 2 * T);
		cmd(pm_mode_pkg::CMD_INTERVAL, 32'h5, 9'h100);
		chk(nvm_q, 32'h5);
		cmd(pm_mode_pkg::CMD_INTERVAL, 32'h0, 9'h100);
		chk(nvm_q, 32'h0);
		chk(wr_count, 32'h2);
		cmd(pm_mode_pkg::CMD_STOP, 32'h0, 9'h100);
		cmd(pm_mode_pkg::CMD_START, 32'h3, 9'h100);
		for (int i = 0; i < 4 * T; i++) begin
			step(1);
			if (fan_max !== 1'b0) chk(fan_max, 1'b0);
		end
	endtask
	task automatic t_health();
		do_reset();
		fan_speed_ok = 1'b0;
		cmd(pm_mode_pkg::CMD_START, 32'h3, 9'h100);
		step(4 * T);
		chk(health[21], 1'b0);
		wait_sig(2, 1'b1, 2 * T);
		fan_speed_ok = 1'b1;
		wait_sig(2, 1'b0, 2 * T);
		laser_ok = 1'b0;
		wait_sig(3, 1'b1, 3 * T);
		cmd(pm_mode_pkg::CMD_WAKE, 32'h0, 9'h180);
		laser_ok = 1'b1;
		wait_sig(3, 1'b0, 2 * T);
		fan_zero = 1'b1;
		wait_sig(4, 1'b1, 3 * T);
		fan_zero = 1'b0;
		step(2 * T);
		chk(health & 32'h0000_0030, 32'h0000_0010);
		cmd(pm_mode_pkg::CMD_STOP, 32'h0, 9'h180);
		do_reset();
		chk(health & 32'h0020_0030, 32'h0);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		bad_count = 0;
		tests_run = 0;
		wr_count = 0;
		rst_in = 1'b1;
		fan_speed_ok = 1'b1;
		fan_zero = 1'b0;
		laser_ok = 1'b1;
		nvm_load = 1'b0;
		nvm_data = 32'h0;
		for (int i = 0; i < 10; i++) begin
			meas_float[319 - 32 * i -: 32] = 32'h4120_0A00 + 32'(i);
			meas_uint[159 - 16 * i -: 16] = 16'h1230 + 16'(i);
		end
		t_modes();
		t_results();
		t_clean();
		t_auto();
		t_health();
		stop_test();
	end
endmodule
